// ==== sac_pkg.sv ====
// Package for the converter control and result register block
package sac_pkg;
    localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
    localparam logic [7:0] ADDR_RES_LO = 8'hBE;
    localparam logic [7:0] ADDR_RES_HI = 8'hBF;
    localparam logic [7:0] ADDR_CTRL = 8'hE8;
    localparam logic [7:0] ADDR_CFG = 8'hBC;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'hF8;
    localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
    localparam logic [5:0] SIX_ZERO = 6'h00;
    localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
    localparam logic [3:0] CONV_SAR_CLOCKS = 4'hB;
    localparam logic [1:0] SM_WRITE = 2'h0;
    localparam logic [1:0] SM_TIMER3 = 2'h1;
    localparam logic [1:0] SM_PIN = 2'h2;
    localparam logic [1:0] SM_TIMER2 = 2'h3;
    localparam int BIT_EN = 7;
    localparam int BIT_TM = 6;
    localparam int BIT_DONE = 5;
    localparam int BIT_BUSY = 4;
    localparam int BIT_WIN = 1;
    localparam int BIT_LJ = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b11
    } sac_state_t;

    typedef struct packed {
        logic enable;
        logic track_mode;
        logic done;
        logic busy;
        logic [1:0] start_mode;
        logic win;
        logic left_justify;
    } sac_ctrl_t;

    typedef struct packed {
        sac_state_t st;
        sac_ctrl_t ctrl;
        logic [3:0] pair_cfg;
        logic [3:0] chan;
        logic [4:0] divider;
        logic [4:0] presc;
        logic [3:0] cnt;
        logic pin_d;
        logic conv_diff;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] rdata;
    } sac_state_all_t;
endpackage

// ==== sac_adc_ctrl.sv ====
// Control, mux selection and result registers of the 10-bit SAR converter
`timescale 1ns/10ps
// Summary of operation
// - Upper nibble of pair and channel registers reads zero, writes ignored.
// - Each pair bit joins inputs 2k/2k+1 differentially, even input positive.
// - Differential results are two's complement; single-ended results unsigned.
// - Codes 0-7 pick an input or configured pair; bit 3 selects temperature.
// - Config bits 7-3 hold the five-bit SAR clock divider.
// - Enable clear keeps converter shut down; set lets it convert.
// - Track mode clear: track continuously except during conversion.
// - Hardware sets the done flag at conversion end; software clears it.
// - Busy reads one during conversion; done flag sets on busy fall at conversion end.
// - Writing one to busy starts only in start mode 00; zero ignored.
// - Start mode picks busy write, timer 3, pin rise, or timer 2.
// - Track mode set, modes 00/01/11: track three SAR clocks, then convert.
// - Track mode set, mode 10: track while pin low, convert on rise.
// - Hardware sets window flag on a match; software clears it.
// - Justify bit selects right placement when clear, left when set.
// - Differential right justified: high bits 1-0 top bits, 7-2 copy bit 1.
// - Single-ended right justified: upper six high bits read zero.
// - Left justified: high holds top eight, low 7-6 bottom two, rest zero.
// - Busy falling edge at conversion end raises the interrupt request when enabled.
module sac_adc_ctrl
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register port from the core
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Start sources
    input wire logic TIMER3_OVF,
    input wire logic TIMER2_OVF,
    input wire logic CONVERT_START_PIN,
    // Analog front end
    input wire logic [9:0] SAR_RESULT,
    input wire logic WINDOW_MATCH,
    output logic SAR_CLOCK,
    output logic CONV_ACTIVE,
    output logic TRACK_ACTIVE,
    output logic ANALOG_ON,
    output logic [7:0] MUX_POS_SEL,
    output logic [7:0] MUX_NEG_SEL,
    output logic TEMP_SEL,
    output logic DIFF_SEL,
    // Interrupt request to the core
    input wire logic IRQ_ENABLE,
    output logic CONV_IRQ
);
    sac_pkg::sac_state_all_t s_r, s_nxt;
    logic sar_tick;
    logic start_evt;
    logic pin_rise;
    logic conv_end;
    logic is_diff;
    logic [9:0] res;
    logic ctrl_wr;
    logic [1:0] mode_eff;
    logic track_on;

    // Pair of the addressed input is differential
    function automatic logic pair_diff(input logic [3:0] cfg, input logic [3:0] ch);
        pair_diff = ~ch[3] & cfg[ch[2:1]];
    endfunction

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ra);
        wr_hit = wr & (a == ra);
    endfunction

    // Format a result word into the high and low bytes
    function automatic logic [15:0] place(input logic [9:0] r, input logic lj, input logic df);
        if (lj)
            place = {r, sac_pkg::SIX_ZERO};
        else
            place = {{6{df & r[9]}}, r};
    endfunction

    assign sar_tick = (s_r.presc == s_r.divider);
    assign pin_rise = CONVERT_START_PIN & ~s_r.pin_d;
    assign is_diff = pair_diff(s_r.pair_cfg, s_r.chan);
    assign conv_end = (s_r.st == sac_pkg::ST_CONV) & sar_tick & (s_r.cnt == 4'h0);
    assign res = SAR_RESULT;
    assign ctrl_wr = wr_hit(REG_WR, REG_ADDR, sac_pkg::ADDR_CTRL);
    // A busy write is judged by the mode it carries, so one write may select and start
    assign mode_eff = ctrl_wr ? REG_WDATA[3:2] : s_r.ctrl.start_mode;

    always_comb
    begin
        unique case (mode_eff)
            sac_pkg::SM_WRITE: start_evt = ctrl_wr & REG_WDATA[sac_pkg::BIT_BUSY];
            sac_pkg::SM_TIMER3: start_evt = TIMER3_OVF;
            sac_pkg::SM_PIN: start_evt = pin_rise;
            sac_pkg::SM_TIMER2: start_evt = TIMER2_OVF;
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pin_d = CONVERT_START_PIN;
        s_nxt.presc = sar_tick ? 5'h00 : s_r.presc + 5'h01;
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                sac_pkg::ADDR_PAIR_CFG: s_nxt.pair_cfg = REG_WDATA[3:0];
                sac_pkg::ADDR_CHAN_SEL: s_nxt.chan = REG_WDATA[3:0];
                sac_pkg::ADDR_CFG: s_nxt.divider = REG_WDATA[7:3];
                sac_pkg::ADDR_RES_LO: s_nxt.res_lo = REG_WDATA;
                sac_pkg::ADDR_RES_HI: s_nxt.res_hi = REG_WDATA;
                sac_pkg::ADDR_CTRL:
                begin
                    s_nxt.ctrl.enable = REG_WDATA[sac_pkg::BIT_EN];
                    s_nxt.ctrl.track_mode = REG_WDATA[sac_pkg::BIT_TM];
                    s_nxt.ctrl.done = REG_WDATA[sac_pkg::BIT_DONE];
                    s_nxt.ctrl.start_mode = REG_WDATA[3:2];
                    s_nxt.ctrl.win = REG_WDATA[sac_pkg::BIT_WIN];
                    s_nxt.ctrl.left_justify = REG_WDATA[sac_pkg::BIT_LJ];
                end
                default: ;
            endcase
        end
        // Keeps the prescaler in range when the divider shrinks mid-count
        if (wr_hit(REG_WR, REG_ADDR, sac_pkg::ADDR_CFG))
            s_nxt.presc = 5'h00;
        unique case (s_r.st)
            sac_pkg::ST_IDLE:
            begin
                // Enable and mode of a same-cycle control write already count here
                if (s_nxt.ctrl.enable && start_evt)
                begin
                    s_nxt.ctrl.busy = 1'b1;
                    s_nxt.conv_diff = is_diff;
                    if (s_nxt.ctrl.track_mode && s_nxt.ctrl.start_mode != sac_pkg::SM_PIN)
                    begin
                        s_nxt.st = sac_pkg::ST_TRACK;
                        s_nxt.cnt = {2'b00, sac_pkg::TRACK_SAR_CLOCKS - 2'h1};
                    end
                    else
                    begin
                        s_nxt.st = sac_pkg::ST_CONV;
                        s_nxt.cnt = sac_pkg::CONV_SAR_CLOCKS - 4'h1;
                    end
                end
            end
            sac_pkg::ST_TRACK:
            begin
                if (sar_tick)
                begin
                    if (s_r.cnt == 4'h0)
                    begin
                        s_nxt.st = sac_pkg::ST_CONV;
                        s_nxt.cnt = sac_pkg::CONV_SAR_CLOCKS - 4'h1;
                    end
                    else
                        s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            sac_pkg::ST_CONV:
            begin
                if (sar_tick && s_r.cnt != 4'h0)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                if (conv_end)
                begin
                    s_nxt.st = sac_pkg::ST_IDLE;
                    s_nxt.ctrl.busy = 1'b0;
                    s_nxt.ctrl.done = 1'b1;
                    {s_nxt.res_hi, s_nxt.res_lo} =
                        place(res, s_r.ctrl.left_justify, s_r.conv_diff);
                end
            end
            default: s_nxt.st = sac_pkg::ST_IDLE;
        endcase
        // Disabling aborts a conversion in flight without flagging completion
        if (!s_nxt.ctrl.enable)
        begin
            s_nxt.st = sac_pkg::ST_IDLE;
            s_nxt.ctrl.busy = 1'b0;
        end
        if (WINDOW_MATCH)
            s_nxt.ctrl.win = 1'b1;
        unique case (REG_ADDR)
            sac_pkg::ADDR_PAIR_CFG: s_nxt.rdata = {sac_pkg::LOW_NIBBLE_ZERO, s_nxt.pair_cfg};
            sac_pkg::ADDR_CHAN_SEL: s_nxt.rdata = {sac_pkg::LOW_NIBBLE_ZERO, s_nxt.chan};
            sac_pkg::ADDR_CFG: s_nxt.rdata = {s_nxt.divider, 3'b000};
            sac_pkg::ADDR_RES_LO: s_nxt.rdata = s_nxt.res_lo;
            sac_pkg::ADDR_RES_HI: s_nxt.rdata = s_nxt.res_hi;
            sac_pkg::ADDR_CTRL: s_nxt.rdata = s_nxt.ctrl;
            default: s_nxt.rdata = sac_pkg::RESET_BYTE;
        endcase
        if (!REG_RD)
            s_nxt.rdata = s_r.rdata;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            s_r <= '0;
            s_r.divider <= sac_pkg::CFG_RESET[7:3];
            s_r.st <= sac_pkg::ST_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    assign REG_RDATA = s_r.rdata;
    assign SAR_CLOCK = sar_tick;
    assign CONV_ACTIVE = (s_r.st == sac_pkg::ST_CONV);
    // Timed low-power tracking only in its window; pin mode tracks while the pin is low
    always_comb
    begin
        track_on = 1'b0;
        if (s_r.st == sac_pkg::ST_TRACK)
            track_on = 1'b1;
        else if (s_r.st == sac_pkg::ST_IDLE)
        begin
            if (!s_r.ctrl.track_mode)
                track_on = 1'b1;
            else if (s_r.ctrl.start_mode == sac_pkg::SM_PIN)
                track_on = ~CONVERT_START_PIN;
        end
    end
    assign TRACK_ACTIVE = s_r.ctrl.enable & track_on;
    assign ANALOG_ON = s_r.ctrl.enable;
    assign TEMP_SEL = s_r.chan[3];
    assign DIFF_SEL = is_diff;
    // Every input line decodes alike; the odd code of a pair falls back to its even member
    for (genvar gi = 0; gi < $bits(MUX_POS_SEL); gi++)
    begin : g_mux
        localparam logic [2:0] IDX = 3'(gi);
        logic pair_hit;
        assign pair_hit = (s_r.chan[2:1] == IDX[2:1]);
        assign MUX_POS_SEL[gi] = ~s_r.chan[3]
            & (is_diff ? ~IDX[0] & pair_hit : s_r.chan[2:0] == IDX);
        assign MUX_NEG_SEL[gi] = is_diff & IDX[0] & pair_hit;
    end
    assign CONV_IRQ = IRQ_ENABLE & conv_end & s_r.ctrl.enable;
endmodule

// ==== sac_adc_ctrl_chk_sva.sv ====
// Port assertions for the converter control block, bound to its top
`timescale 1ns/10ps
module sac_adc_ctrl_chk
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Start sources
    input wire logic TIMER3_OVF,
    input wire logic TIMER2_OVF,
    input wire logic CONVERT_START_PIN,
    // Converter status and selects
    input wire logic CONV_ACTIVE,
    input wire logic TRACK_ACTIVE,
    input wire logic ANALOG_ON,
    input wire logic [7:0] MUX_POS_SEL,
    input wire logic [7:0] MUX_NEG_SEL,
    input wire logic TEMP_SEL,
    input wire logic DIFF_SEL,
    // Interrupt request
    input wire logic IRQ_ENABLE,
    input wire logic CONV_IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic idle_wr;
    assign idle_wr = REG_WR && REG_ADDR == sac_pkg::ADDR_CTRL && !CONV_ACTIVE;
    property p_nib; REG_RD && REG_ADDR[7:1] == 7'h5D |=> REG_RDATA[7:4] == 4'h0; endproperty
    a_nib: assert property (p_nib) else $error("upper nibble not zero");
    property p_tmp; REG_WR && REG_ADDR == 8'hBB |=> TEMP_SEL == $past(REG_WDATA[3]); endproperty
    a_tmp: assert property (p_tmp) else $error("sensor select wrong");
    property p_pair;
        DIFF_SEL && !TEMP_SEL |-> $onehot(MUX_POS_SEL) && MUX_NEG_SEL == MUX_POS_SEL << 1
            && (MUX_POS_SEL & 8'h55) != 8'h00;
    endproperty
    a_pair: assert property (p_pair) else $error("pair selects wrong");
    property p_off; !ANALOG_ON |-> !CONV_ACTIVE && !TRACK_ACTIVE; endproperty
    a_off: assert property (p_off) else $error("active while shut down");
    property p_trk; TRACK_ACTIVE |-> !CONV_ACTIVE; endproperty
    a_trk: assert property (p_trk) else $error("tracking during conversion");
    property p_go; idle_wr && ANALOG_ON && REG_WDATA[7:2] == 6'h24 |=> CONV_ACTIVE; endproperty
    a_go: assert property (p_go) else $error("busy write did not start");
    // A start in another mode needs its own trigger, so none may be present here
    property p_nogo;
        idle_wr && REG_WDATA[6:4] == 3'h1 && REG_WDATA[3:2] != 2'h0 && !TIMER3_OVF
            && !TIMER2_OVF && $stable(CONVERT_START_PIN) |=> !CONV_ACTIVE;
    endproperty
    a_nogo: assert property (p_nogo) else $error("busy write started wrongly");
    property p_long; $rose(CONV_ACTIVE) |-> CONV_ACTIVE [*8]; endproperty
    a_long: assert property (p_long) else $error("conversion too short");
    property p_end; CONV_IRQ |=> !CONV_ACTIVE; endproperty
    a_end: assert property (p_end) else $error("busy still high after end");
    property p_irq; CONV_IRQ |-> IRQ_ENABLE; endproperty
    a_irq: assert property (p_irq) else $error("request while not enabled");
    c_irq: cover property (CONV_IRQ);
    c_trk: cover property (TRACK_ACTIVE ##1 CONV_ACTIVE);
    c_diff: cover property (DIFF_SEL);
endmodule
bind sac_adc_ctrl sac_adc_ctrl_chk u_chk (.*);

// ==== sac_core_model.sv ====
// Behavioural processor core that drives the register port
`timescale 1ns/10ps
module sac_core_model
(
    // Clock
    input wire logic MCLK,
    // Register port
    output logic [7:0] REG_ADDR,
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_WDATA
);
    initial
    begin
        REG_ADDR = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 8'h00;
    end
    // Released address and data lines show the inverse so stale values never look valid; strobes drop to zero
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = w;
        REG_RD = !w;
        @(negedge MCLK);
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask
endmodule

// ==== sac_adc_ctrl_tb.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sac_adc_ctrl_tb;
    logic MCLK, SYS_RST, REG_WR, REG_RD, TIMER3_OVF, TIMER2_OVF, CONVERT_START_PIN;
    logic WINDOW_MATCH, SAR_CLOCK, CONV_ACTIVE, TRACK_ACTIVE, ANALOG_ON, TEMP_SEL;
    logic DIFF_SEL, IRQ_ENABLE, CONV_IRQ, rd_seen;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, MUX_POS_SEL, MUX_NEG_SEL, ctl;
    logic [9:0] SAR_RESULT;
    logic [3:0] cfg, code;
    logic [7:0] expq[$];
    logic [7:0] adr[7] = '{8'hBA, 8'hBB, 8'hBE, 8'hBF, 8'hE8, 8'hBC, 8'h00};
    int fails, n_checks, n;
    int lat[2][4];
    sac_adc_ctrl DUT (.*);
    sac_core_model core (.*);
    initial
    begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        core.acc(1'b0, a, 8'h00);
    endtask
    // Read data is registered, so it is judged one cycle after the strobe
    always @(posedge MCLK) rd_seen <= REG_RD;
    always @(negedge MCLK)
        if (rd_seen === 1'b1)
            cmp(REG_RDATA, expq.pop_front());
    task automatic wait_irq(output int k);
        k = 0;
        while (CONV_IRQ !== 1'b1 && k < 300)
        begin
            @(negedge MCLK);
            k++;
        end
        if (k >= 300)
            fails++;
    endtask
    task automatic fire(input logic [1:0] m);
        TIMER3_OVF = (m == sac_pkg::SM_TIMER3);
        TIMER2_OVF = (m == sac_pkg::SM_TIMER2);
        CONVERT_START_PIN = (m == sac_pkg::SM_PIN);
        @(negedge MCLK);
        TIMER3_OVF = 1'b0;
        TIMER2_OVF = 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {SYS_RST, TIMER3_OVF, TIMER2_OVF, CONVERT_START_PIN, WINDOW_MATCH} = 5'h10;
        {IRQ_ENABLE, SAR_RESULT, fails, n_checks} = {1'b1, 10'h000, 64'h0};
        void'($urandom(86));
        repeat (12) @(negedge MCLK);
        SYS_RST = 1'b0;
        foreach (adr[i]) rd(adr[i], i == 5 ? sac_pkg::CFG_RESET : 8'h00);
        wr(8'hBA, 8'hFF);
        rd(8'hBA, 8'h0F);
        wr(8'hBB, 8'hF3);
        rd(8'hBB, 8'h03);
        for (int i = 0; i < 16; i++)
        begin
            cfg = 4'($urandom);
            code = 4'($urandom % 9);
            if (!code[3] && code[0] && cfg[code[2:1]]) code--;
            wr(8'hBA, {4'h0, cfg});
            wr(8'hBB, {4'h0, code});
            cmp({7'h00, TEMP_SEL}, {7'h00, code[3]});
            if (!code[3]) cmp(MUX_POS_SEL, 8'h01 << code);
            if (!code[3]) cmp({7'h00, DIFF_SEL}, {7'h00, cfg[code[2:1]]});
            if (!code[3] && cfg[code[2:1]]) cmp(MUX_NEG_SEL, 8'h02 << code);
        end
        wr(sac_pkg::ADDR_CFG, 8'h20);
        rd(sac_pkg::ADDR_CFG, 8'h20);
        for (n = 0; SAR_CLOCK !== 1'b1 && n < 50; n++) @(negedge MCLK);
        n = 1;
        @(negedge MCLK);
        while (SAR_CLOCK !== 1'b1 && n < 50)
        begin
            @(negedge MCLK);
            n++;
        end
        cmp(8'(n), 8'h05);
        // Divider zero gives one SAR tick per cycle, so track length is in cycles
        wr(sac_pkg::ADDR_CFG, 8'h00);
        wr(8'hE8, 8'h80);
        cmp({7'h00, ANALOG_ON}, 8'h01);
        for (int t = 0; t < 2; t++)
            for (int m = 0; m < 4; m++)
            begin
                SAR_RESULT = 10'($urandom);
                CONVERT_START_PIN = 1'b0;
                ctl = {1'b1, t[0], 2'h0, 2'(m), 1'b0, m[0]};
                wr(8'hBA, {7'h00, t[0]});
                wr(8'hBB, 8'h00);
                wr(8'hE8, ctl | 8'h10);
                if (m != 0) cmp({7'h00, CONV_ACTIVE}, 8'h00);
                if (m != 0) cmp({7'h00, TRACK_ACTIVE}, {7'h00, t == 0 || m == 2});
                if (m != 0) fire(2'(m));
                wait_irq(lat[t][m]);
                repeat (4) @(negedge MCLK);
                rd(8'hE8, ctl | 8'h20);
                rd(8'hBF, m[0] ? SAR_RESULT[9:2]
                    : {{6{t[0] & SAR_RESULT[9]}}, SAR_RESULT[9:8]});
                rd(8'hBE, m[0] ? {SAR_RESULT[1:0], 6'h00} : SAR_RESULT[7:0]);
            end
        for (int m = 0; m < 4; m++)
            cmp(8'(lat[1][m] - lat[0][m]), m == 2 ? 8'h00 : 8'h03);
        WINDOW_MATCH = 1'b1;
        @(negedge MCLK);
        WINDOW_MATCH = 1'b0;
        repeat (4) @(negedge MCLK);
        rd(8'hE8, 8'hEF);
        // A masked request must stay low while the completion flag still sets
        IRQ_ENABLE = 1'b0;
        wr(8'hE8, 8'h90);
        repeat (20)
        begin
            @(negedge MCLK);
            cmp({7'h00, CONV_IRQ}, 8'h00);
        end
        rd(8'hE8, 8'hA0);
        wr(8'hE8, 8'h10);
        @(negedge MCLK);
        cmp({6'h00, ANALOG_ON, CONV_ACTIVE}, 8'h00);
        rd(8'hE8, 8'h00);
        repeat (3) @(negedge MCLK);
        end_of_test();
    end
    initial
    begin
        #500000;
        fails++;
        end_of_test();
    end
endmodule
